/* File: verilog/tcc_pkg.sv */
// Constants shared by the timer capture/compare channel block
package tcc_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int NCH = 2;
  localparam int CW = 16;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_SLAVE = 8'h04;
  localparam logic [7:0] ADDR_MODE = 8'h08;
  localparam logic [7:0] ADDR_ENABLE = 8'h0C;
  localparam logic [7:0] ADDR_EVGEN = 8'h10;
  localparam logic [7:0] ADDR_COUNT = 8'h14;
  localparam logic [7:0] ADDR_IRQCFG = 8'h18;
  localparam logic [7:0] ADDR_FLAG = 8'h1C;
  localparam logic [7:0] ADDR_MISS = 8'h20;
  localparam logic [7:0] ADDR_CCR0 = 8'h24;
  localparam logic [7:0] ADDR_CCR1 = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int SM_MODE_LSB = 0;
  localparam int SM_TRIG_LSB = 4;
  localparam int SM_ETF_LSB = 8;
  localparam int SM_ETPS_LSB = 12;
  localparam int SM_ECE_BIT = 14;
  localparam int SM_ETP_BIT = 15;
  localparam int MD_STRIDE = 8;
  localparam int MD_DIR_LSB = 0;
  localparam int MD_PSC_LSB = 2;
  localparam int MD_BUF_BIT = 3;
  localparam int MD_OCM_LSB = 4;
  localparam int MD_FILT_LSB = 4;
  localparam int EN_STRIDE = 4;
  localparam int EN_BIT = 0;
  localparam int POL_BIT = 1;
  localparam int EG_UG_BIT = 0;
  localparam int EG_CCG_LSB = 1;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] DIR_OUTPUT = 2'h0;
  localparam logic [1:0] DIR_OWN = 2'h1;
  localparam logic [1:0] DIR_NEIGH = 2'h2;
  localparam logic [2:0] OCM_FROZEN = 3'h0;
  localparam logic [2:0] OCM_SET = 3'h1;
  localparam logic [2:0] OCM_CLEAR = 3'h2;
  localparam logic [2:0] OCM_TOGGLE = 3'h3;
  localparam logic [2:0] OCM_FORCE_LOW = 3'h4;
  localparam logic [2:0] OCM_FORCE_HIGH = 3'h5;
  localparam logic [2:0] SMS_RESET = 3'h4;
  localparam logic [2:0] TS_CH0_EDGE = 3'h5;
  localparam logic [2:0] TS_CH1_EDGE = 3'h6;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_WORD = 32'h0;
  localparam logic [CW-1:0] RST_COUNT = 16'h0;
  localparam logic [CW-1:0] COUNT_MAX = 16'hFFFF;
  localparam logic [4:0] FILT_MAX_LEN = 5'h10;
  localparam logic [2:0] FILT_MAX_SHIFT = 3'h4;

endpackage

/* File: verilog/tcc_in_filter.sv */
// Input synchroniser, sample-count digital filter and edge pulses
`timescale 1ns/1ps
module tcc_in_filter (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Raw pin and filter length code
  input wire logic pin_i,
  input wire logic [3:0] filt_i,
  // Filtered level and edge pulses
  output logic level_o,
  output logic rise_o,
  output logic fall_o
);

  logic sync1_r;
  logic sync2_r;
  logic [4:0] cnt_r;
  logic [4:0] len;
  logic accept;

  // Samples needed: 1 for code 0, 2^code up to 16
  assign len = (filt_i == 4'h0) ? 5'h01 :
               (filt_i > {1'b0, tcc_pkg::FILT_MAX_SHIFT}) ? tcc_pkg::FILT_MAX_LEN :
               5'(32'd1 << filt_i);
  assign accept = (sync2_r != level_o) && ((cnt_r + 5'h01) >= len);

  // Two-stage synchroniser; only the second stage is looked at
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= pin_i;
      sync2_r <= sync1_r;
    end
  end

  // Count consecutive samples at the new level, then take it
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cnt_r <= 5'h00;
      level_o <= 1'b0;
      rise_o <= 1'b0;
      fall_o <= 1'b0;
    end else begin
      cnt_r <= (sync2_r == level_o || accept) ? 5'h00 : cnt_r + 5'h01;
      level_o <= accept ? sync2_r : level_o;
      rise_o <= accept & sync2_r;
      fall_o <= accept & ~sync2_r;
    end
  end

endmodule

/* File: verilog/tcc_prescale.sv */
// Event prescaler passing one event in 1, 2, 4 or 8
`timescale 1ns/1ps
module tcc_prescale (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic clear_i,
  input wire logic [1:0] ratio_i,
  // Events in and out
  input wire logic ev_i,
  output logic pulse_o
);

  logic [2:0] cnt_r;
  logic [2:0] last;
  logic wrap;

  // Last count before the output fires
  assign last = 3'((32'd1 << ratio_i) - 32'd1);
  assign wrap = ev_i && (cnt_r == last);

  // Count events, fire and restart on the last one
  always_ff @(posedge clk_sys_i) begin
    if (rst_i || clear_i) begin
      cnt_r <= 3'h0;
      pulse_o <= 1'b0;
    end else begin
      cnt_r <= wrap ? 3'h0 : (ev_i ? cnt_r + 3'h1 : cnt_r);
      pulse_o <= wrap;
    end
  end

endmodule

/* File: verilog/tcc_top.sv */
// Timer capture/compare channels with external trigger clock path and AHB-Lite registers
//
// The AHB-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/1ps
module tcc_top (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Timer pins
  input wire logic [1:0] channel_input_i,
  input wire logic external_trigger_input_i,
  output logic [1:0] compare_output_pin_o,
  // Interrupt request
  output logic irq_o
);

  localparam int NCH = tcc_pkg::NCH;
  localparam int CW = tcc_pkg::CW;

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic counter_enable_bit_r;
  logic [15:0] slave_mode_control_reg_r;
  logic [15:0] channel_mode_reg_r;
  logic [7:0] channel_enable_reg_r;
  logic [NCH-1:0] interrupt_config_reg_r;
  logic [NCH-1:0] channel_event_flag_r;
  logic [NCH-1:0] missed_capture_flag_r;
  logic [NCH:0] event_generation_reg_r;
  logic [CW-1:0] count_r;
  logic step_r;
  logic etr_tick_r;
  logic trig_d_r;
  logic [NCH-1:0][CW-1:0] buf_r;
  logic [NCH-1:0][CW-1:0] shadow_r;
  logic [NCH-1:0] copy_r;
  logic [NCH-1:0] compare_reference_r;
  logic wr_pend_r;
  logic [7:0] wr_addr_r;

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  wire acc = hsel_i & htrans_i[1] & hready_i;
  wire rd_acc = acc & ~hwrite_i;
  wire [7:0] aoff = haddr_i[7:0];
  wire we_ctrl = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_CTRL);
  wire we_slave = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_SLAVE);
  wire we_mode = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_MODE);
  wire we_enable = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_ENABLE);
  wire we_evgen = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_EVGEN);
  wire we_irqcfg = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_IRQCFG);
  wire we_flag = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_FLAG);
  wire we_miss = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_MISS);
  wire [NCH-1:0] we_ccr;
  wire [NCH-1:0] rd_ccr;
  wire [NCH-1:0] flag_w1c = we_flag ? hwdata_i[NCH-1:0] : '0;
  wire [NCH-1:0] miss_w1c = we_miss ? hwdata_i[NCH-1:0] : '0;
  assign we_ccr[0] = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_CCR0);
  assign we_ccr[1] = wr_pend_r && (wr_addr_r == tcc_pkg::ADDR_CCR1);
  assign rd_ccr[0] = rd_acc && (aoff == tcc_pkg::ADDR_CCR0);
  assign rd_ccr[1] = rd_acc && (aoff == tcc_pkg::ADDR_CCR1);

  // Read data selection; unmapped offsets read zero
  wire [31:0] rdata =
    (aoff == tcc_pkg::ADDR_CTRL) ? {31'h0, counter_enable_bit_r} :
    (aoff == tcc_pkg::ADDR_SLAVE) ? {16'h0, slave_mode_control_reg_r} :
    (aoff == tcc_pkg::ADDR_MODE) ? {16'h0, channel_mode_reg_r} :
    (aoff == tcc_pkg::ADDR_ENABLE) ? {24'h0, channel_enable_reg_r} :
    (aoff == tcc_pkg::ADDR_COUNT) ? {16'h0, count_r} :
    (aoff == tcc_pkg::ADDR_IRQCFG) ? {30'h0, interrupt_config_reg_r} :
    (aoff == tcc_pkg::ADDR_FLAG) ? {30'h0, channel_event_flag_r} :
    (aoff == tcc_pkg::ADDR_MISS) ? {30'h0, missed_capture_flag_r} :
    (aoff == tcc_pkg::ADDR_CCR0) ? {16'h0, buf_r[0]} :
    (aoff == tcc_pkg::ADDR_CCR1) ? {16'h0, buf_r[1]} :
    32'h0;

  // ----------------------------------------------------------------
  // Slave mode and event generation fields
  // ----------------------------------------------------------------
  wire [2:0] slave_mode_select = slave_mode_control_reg_r[tcc_pkg::SM_MODE_LSB +: 3];
  wire [2:0] trigger_select = slave_mode_control_reg_r[tcc_pkg::SM_TRIG_LSB +: 3];
  wire [3:0] ext_trigger_filter = slave_mode_control_reg_r[tcc_pkg::SM_ETF_LSB +: 4];
  wire [1:0] ext_trigger_prescale = slave_mode_control_reg_r[tcc_pkg::SM_ETPS_LSB +: 2];
  wire ext_clock_mode2_enable = slave_mode_control_reg_r[tcc_pkg::SM_ECE_BIT];
  wire ext_trigger_polarity = slave_mode_control_reg_r[tcc_pkg::SM_ETP_BIT];
  wire update_gen = event_generation_reg_r[tcc_pkg::EG_UG_BIT];
  wire [NCH-1:0] channel_event_generate = event_generation_reg_r[tcc_pkg::EG_CCG_LSB +: NCH];

  // ----------------------------------------------------------------
  // External trigger path
  // ----------------------------------------------------------------
  logic etr_rise;
  logic etr_fall;
  logic prescaled_ext_trigger;

  // Synchronise and filter the trigger; code 0 passes each sample
  tcc_in_filter u_etr_filter (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .pin_i(external_trigger_input_i),
    .filt_i(ext_trigger_filter),
    .level_o(),
    .rise_o(etr_rise),
    .fall_o(etr_fall)
  );

  // Polarity 0 counts rising edges; prescale divides them
  wire etr_edge = ext_trigger_polarity ? etr_fall : etr_rise;
  tcc_prescale u_etr_prescale (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .clear_i(~ext_clock_mode2_enable),
    .ratio_i(ext_trigger_prescale),
    .ev_i(etr_edge),
    .pulse_o(prescaled_ext_trigger)
  );

  // ----------------------------------------------------------------
  // Channel input stage
  // ----------------------------------------------------------------
  logic [NCH-1:0] in_rise;
  logic [NCH-1:0] in_fall;
  logic [NCH-1:0] filtered_channel_input;
  logic [NCH-1:0] filtered_edge_signal;
  logic [NCH-1:0] prescaled_capture_cmd;
  wire [NCH-1:0] is_input;
  wire [NCH-1:0] ch_en;
  wire [NCH-1:0] ch_pol;
  wire [NCH-1:0] sel_edge;
  wire [NCH-1:0] capture;
  wire [NCH-1:0] cmp_event;
  wire [NCH-1:0][CW-1:0] buf_nxt;
  wire [NCH-1:0][CW-1:0] shadow_nxt;
  wire [NCH-1:0] flag_nxt;
  wire [NCH-1:0] miss_nxt;
  wire [NCH-1:0] ref_nxt;
  wire [NCH-1:0] pin_nxt;

  // ----------------------------------------------------------------
  // Counter and update event
  // ----------------------------------------------------------------
  wire count_tick = ext_clock_mode2_enable ? etr_tick_r : 1'b1;
  wire advance = counter_enable_bit_r & count_tick;
  wire trig_in = (trigger_select == tcc_pkg::TS_CH0_EDGE) ? filtered_edge_signal[0] :
                 (trigger_select == tcc_pkg::TS_CH1_EDGE) ? filtered_edge_signal[1] :
                 1'b0;
  // Slave trigger is taken one cycle late, in step with the capture path:
  // the capture on the same edge still sees the count of the ending period
  // before the counter is zeroed, so the period lands in the register
  wire slave_reset = (slave_mode_select == tcc_pkg::SMS_RESET) & trig_d_r;
  wire update_event = update_gen | slave_reset | (advance & (count_r == tcc_pkg::COUNT_MAX));
  wire [CW-1:0] count_nxt = (update_gen | slave_reset) ? tcc_pkg::RST_COUNT :
                            advance ? count_r + 16'h0001 : count_r;

  // Per channel: filter, routing, prescale, buffer/shadow, compare
  genvar y;
  generate
    for (y = 0; y < NCH; y++) begin : g_ch
      localparam int O = NCH - 1 - y;
      wire [1:0] dir = channel_mode_reg_r[y*tcc_pkg::MD_STRIDE + tcc_pkg::MD_DIR_LSB +: 2];
      wire [1:0] psc = channel_mode_reg_r[y*tcc_pkg::MD_STRIDE + tcc_pkg::MD_PSC_LSB +: 2];
      wire [3:0] filt = channel_mode_reg_r[y*tcc_pkg::MD_STRIDE + tcc_pkg::MD_FILT_LSB +: 4];
      wire bufen = channel_mode_reg_r[y*tcc_pkg::MD_STRIDE + tcc_pkg::MD_BUF_BIT];
      wire [2:0] ocm = channel_mode_reg_r[y*tcc_pkg::MD_STRIDE + tcc_pkg::MD_OCM_LSB +: 3];
      wire [CW-1:0] cmp_val = bufen ? shadow_r[y] : buf_r[y];
      wire match = ~is_input[y] & step_r & (count_r == cmp_val);

      // Filtered input with programmable sample count
      tcc_in_filter u_filter (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .pin_i(channel_input_i[y]),
        .filt_i(filt),
        .level_o(filtered_channel_input[y]),
        .rise_o(in_rise[y]),
        .fall_o(in_fall[y])
      );

      // Capture prescaler; cleared while the channel is not capturing
      tcc_prescale u_prescale (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .clear_i(~(is_input[y] & ch_en[y])),
        .ratio_i(psc),
        .ev_i(sel_edge[y] & is_input[y]),
        .pulse_o(prescaled_capture_cmd[y])
      );

      // Routing and polarity of the capture source
      assign ch_en[y] = channel_enable_reg_r[y*tcc_pkg::EN_STRIDE + tcc_pkg::EN_BIT];
      assign ch_pol[y] = channel_enable_reg_r[y*tcc_pkg::EN_STRIDE + tcc_pkg::POL_BIT];
      assign is_input[y] = (dir != tcc_pkg::DIR_OUTPUT);
      assign filtered_edge_signal[y] = ch_pol[y] ? in_fall[y] : in_rise[y];
      assign sel_edge[y] = (dir == tcc_pkg::DIR_NEIGH) ?
                           (ch_pol[y] ? in_fall[O] : in_rise[O]) : filtered_edge_signal[y];

      // Capture or compare events, including software generation
      assign capture[y] = is_input[y] & ch_en[y] &
                          (prescaled_capture_cmd[y] | channel_event_generate[y]);
      assign cmp_event[y] = match | (~is_input[y] & channel_event_generate[y]);

      // Shadow: counter on capture, buffer at update when buffered
      assign shadow_nxt[y] = is_input[y] ? (capture[y] ? count_r : shadow_r[y]) :
                             ((~bufen | update_event) ? buf_r[y] : shadow_r[y]);
      // Buffer: shadow copy after capture, else software write in output mode
      assign buf_nxt[y] = copy_r[y] ? shadow_r[y] :
                          (we_ccr[y] & ~is_input[y]) ? hwdata_i[CW-1:0] : buf_r[y];

      // Flags; setting beats write-one and read clears
      assign flag_nxt[y] = (is_input[y] & copy_r[y]) | cmp_event[y] |
                           (channel_event_flag_r[y] & ~flag_w1c[y] & ~rd_ccr[y]);
      assign miss_nxt[y] = (is_input[y] & copy_r[y] & channel_event_flag_r[y]) |
                           (missed_capture_flag_r[y] & ~miss_w1c[y]);

      // Reference action; the update event plays no part here
      assign ref_nxt[y] = is_input[y] ? compare_reference_r[y] :
        (ocm == tcc_pkg::OCM_FORCE_HIGH) ? 1'b1 :
        (ocm == tcc_pkg::OCM_FORCE_LOW) ? 1'b0 :
        (cmp_event[y] && ocm == tcc_pkg::OCM_SET) ? 1'b1 :
        (cmp_event[y] && ocm == tcc_pkg::OCM_CLEAR) ? 1'b0 :
        (cmp_event[y] && ocm == tcc_pkg::OCM_TOGGLE) ? ~compare_reference_r[y] :
        compare_reference_r[y];
      // Pin is the reference, inverted by polarity, low when disabled
      assign pin_nxt[y] = ch_en[y] & ~is_input[y] & (compare_reference_r[y] ^ ch_pol[y]);
    end
  endgenerate

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------

  // Bus handshake: writes take one wait state, reads none
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hreadyout_o <= 1'b1;
      hresp_o <= 1'b0;
      hrdata_o <= tcc_pkg::RST_WORD;
    end else begin
      wr_pend_r <= acc & hwrite_i;
      wr_addr_r <= acc ? aoff : wr_addr_r;
      hreadyout_o <= ~(acc & hwrite_i);
      hresp_o <= 1'b0;
      hrdata_o <= rd_acc ? rdata : hrdata_o;
    end
  end

  // Software control registers
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      counter_enable_bit_r <= 1'b0;
      slave_mode_control_reg_r <= 16'h0;
      channel_mode_reg_r <= 16'h0;
      channel_enable_reg_r <= 8'h0;
      interrupt_config_reg_r <= '0;
      event_generation_reg_r <= '0;
    end else begin
      counter_enable_bit_r <= we_ctrl ? hwdata_i[0] : counter_enable_bit_r;
      slave_mode_control_reg_r <= we_slave ? hwdata_i[15:0] : slave_mode_control_reg_r;
      channel_mode_reg_r <= we_mode ? hwdata_i[15:0] : channel_mode_reg_r;
      channel_enable_reg_r <= we_enable ? hwdata_i[7:0] : channel_enable_reg_r;
      interrupt_config_reg_r <= we_irqcfg ? hwdata_i[NCH-1:0] : interrupt_config_reg_r;
      event_generation_reg_r <= we_evgen ? hwdata_i[NCH:0] : '0;
    end
  end

  // Counter, resynchronised trigger tick and compare step marker
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      count_r <= tcc_pkg::RST_COUNT;
      etr_tick_r <= 1'b0;
      trig_d_r <= 1'b0;
      step_r <= 1'b0;
    end else begin
      count_r <= count_nxt;
      etr_tick_r <= prescaled_ext_trigger;
      trig_d_r <= trig_in;
      step_r <= advance | update_gen | slave_reset;
    end
  end

  // Channel state, flags, pins and interrupt request
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      buf_r <= '0;
      shadow_r <= '0;
      copy_r <= '0;
      channel_event_flag_r <= '0;
      missed_capture_flag_r <= '0;
      compare_reference_r <= '0;
      compare_output_pin_o <= '0;
      irq_o <= 1'b0;
    end else begin
      buf_r <= buf_nxt;
      shadow_r <= shadow_nxt;
      copy_r <= capture;
      channel_event_flag_r <= flag_nxt;
      missed_capture_flag_r <= miss_nxt;
      compare_reference_r <= ref_nxt;
      compare_output_pin_o <= pin_nxt;
      irq_o <= |(channel_event_flag_r & interrupt_config_reg_r);
    end
  end

endmodule

/* File: testbench/tcc_pins_model.sv */
// Pin-side model: channel inputs that bounce on each change, trigger pass-through
`timescale 1ns/1ps
module tcc_pins_model (
  // Clock
  input wire logic clk_sys_i,
  // Commanded levels
  input wire logic [1:0] lvl_i,
  input wire logic etr_i,
  // Pin levels
  output logic [1:0] ch_o = 2'h0,
  output logic etr_o = 1'b0
);
  logic [1:0] last_r = 2'h0;
  logic [2:0] bnc_r = 3'h0;
  int seed = 16;
  // A level change shows random values for four cycles, shorter than the filter
  always_ff @(posedge clk_sys_i) begin
    last_r <= lvl_i;
    if (lvl_i != last_r) bnc_r <= 3'h4;
    else if (bnc_r != 3'h0) bnc_r <= bnc_r - 3'h1;
    ch_o <= (bnc_r != 3'h0) ? 2'($random(seed)) : lvl_i;
    etr_o <= etr_i;
  end
endmodule

/* File: testbench/tcc_monitor.sv */
// Checker for bus timing and compare pin relations of the channel block
`timescale 1ns/1ps
module tcc_monitor (
  // Clock, reset and bus
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  input wire logic [31:0] hrdata_o,
  input wire logic hreadyout_o,
  // Pins
  input wire logic [1:0] compare_output_pin_o,
  input wire logic irq_o
);
  logic wr_r;
  logic [7:0] a_r;
  logic [15:0] mode_r;
  logic [5:0] en_r;
  logic [1:0] msk_r;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  // Shadow of the mode, enable and mask registers taken from bus writes
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      wr_r <= 1'b0;
      a_r <= 8'h00;
      mode_r <= 16'h0000;
      en_r <= 6'h00;
      msk_r <= 2'h0;
    end else if (hready_i) begin
      wr_r <= hsel_i & htrans_i[1] & hwrite_i;
      a_r <= haddr_i[7:0];
      if (wr_r && a_r == tcc_pkg::ADDR_MODE) mode_r <= hwdata_i[15:0];
      if (wr_r && a_r == tcc_pkg::ADDR_ENABLE) en_r <= hwdata_i[5:0];
      if (wr_r && a_r == tcc_pkg::ADDR_IRQCFG) msk_r <= hwdata_i[1:0];
    end
  end
  // Transfer takes and per-channel pin conditions
  wire take = hsel_i & htrans_i[1] & hready_i;
  wire quiet0 = !en_r[0] || mode_r[1:0] != 2'h0;
  wire quiet1 = !en_r[4] || mode_r[9:8] != 2'h0;
  wire force0 = !quiet0 && mode_r[6:5] == 2'h2;
  wire force1 = !quiet1 && mode_r[14:13] == 2'h2;
  sequence cfg_held;
    ($stable(mode_r) && $stable(en_r))[*4];
  endsequence
  sequence wr_phase;
    !hreadyout_o ##1 hreadyout_o;
  endsequence
  write_wait_a: assert property (take && hwrite_i |=> wr_phase)
    else $error("write data phase not two cycles");
  read_nowait_a: assert property (take && !hwrite_i |=> hreadyout_o)
    else $error("read data phase stalled");
  rdata_hold_a: assert property (!(take && !hwrite_i) |=> $stable(hrdata_o))
    else $error("read data changed without a read");
  force0_a: assert property (cfg_held ##0 force0 |-> compare_output_pin_o[0] == (mode_r[4] ^ en_r[1]))
    else $error("channel 0 forced level wrong");
  force1_a: assert property (cfg_held ##0 force1 |-> compare_output_pin_o[1] == (mode_r[12] ^ en_r[5]))
    else $error("channel 1 forced level wrong");
  quiet0_a: assert property (cfg_held ##0 quiet0 |-> !compare_output_pin_o[0])
    else $error("channel 0 pin driven while input or off");
  quiet1_a: assert property (cfg_held ##0 quiet1 |-> !compare_output_pin_o[1])
    else $error("channel 1 pin driven while input or off");
  irq_mask_a: assert property ($stable(msk_r)[*3] ##0 msk_r == 2'h0 |-> !irq_o)
    else $error("interrupt raised while masked");
endmodule

bind tcc_top tcc_monitor u_mon (.clk_sys_i, .rst_i, .hsel_i, .haddr_i, .htrans_i, .hwrite_i,
  .hwdata_i, .hready_i, .hrdata_o, .hreadyout_o, .compare_output_pin_o, .irq_o);

/* File: testbench/tcc_top_tb_top.sv */
// Self-checking bench for the timer capture/compare channel block
`timescale 1ns/1ps
module tcc_top_tb_top;
  logic clk_sys_i = 1'b0, rst_i = 1'b1, hsel = 1'b0, hwrite = 1'b0, external_trigger_input = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, q, c0;
  logic [1:0] htrans = 2'h0, lvl = 2'h0, ch_pin, pin;
  logic hready, hresp, etr_pin, irq, pol, ref_s = 1'b0;
  int failures = 0, checks = 0, seed = 16, v, h, l;
  logic [7:0] al [5] = '{tcc_pkg::ADDR_FLAG, tcc_pkg::ADDR_MISS, tcc_pkg::ADDR_CCR0,
    tcc_pkg::ADDR_COUNT, 8'h40};
  logic [2:0] ml [7] = '{tcc_pkg::OCM_FORCE_LOW, tcc_pkg::OCM_SET, tcc_pkg::OCM_TOGGLE,
    tcc_pkg::OCM_FROZEN, tcc_pkg::OCM_TOGGLE, tcc_pkg::OCM_CLEAR, tcc_pkg::OCM_FORCE_HIGH};
  initial begin
    forever #4 clk_sys_i = ~clk_sys_i;
  end
  tcc_top DUT (.clk_sys_i, .rst_i, .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
    .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata), .hready_i(hready), .hrdata_o(hrdata),
    .hreadyout_o(hready), .hresp_o(hresp), .channel_input_i(ch_pin),
    .external_trigger_input_i(etr_pin), .compare_output_pin_o(pin), .irq_o(irq));
  tcc_pins_model PINS (.clk_sys_i, .lvl_i(lvl), .etr_i(external_trigger_input), .ch_o(ch_pin), .etr_o(etr_pin));
  // Single AHB-Lite transfer; read data lands in q
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys_i);
    hsel <= 1'b1;
    haddr <= {24'h000000, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk_sys_i); while (hready !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Reference level after one match in mode m
  function automatic logic exp_ref(input logic [2:0] m, input logic p);
    case (m)
      tcc_pkg::OCM_SET, tcc_pkg::OCM_FORCE_HIGH: return 1'b1;
      tcc_pkg::OCM_CLEAR, tcc_pkg::OCM_FORCE_LOW: return 1'b0;
      tcc_pkg::OCM_TOGGLE: return !p;
      default: return p;
    endcase
  endfunction
  function automatic logic [31:0] near(input logic [31:0] g, input int e);
    return {31'h0, int'(g) >= e - 6 && int'(g) <= e + 6};
  endfunction
  // One channel 1 compare run from a stopped, zeroed counter
  task automatic cmp_run(input logic [2:0] m, input logic b, input logic [15:0] v2);
    wr(tcc_pkg::ADDR_CTRL, 32'h0);
    wr(tcc_pkg::ADDR_MODE, {16'h0000, {2{1'b0, m, b, 3'h0}}});
    wr(tcc_pkg::ADDR_CCR1, {16'h0000, 16'(v)});
    wr(tcc_pkg::ADDR_EVGEN, 32'h1);
    wr(tcc_pkg::ADDR_CCR1, {16'h0000, v2});
    wr(tcc_pkg::ADDR_FLAG, 32'h2);
    wr(tcc_pkg::ADDR_CTRL, 32'h1);
    cyc(v + 12);
    ref_s = exp_ref(m, ref_s);
    chk("pin1", {31'h0, ref_s ^ pol}, {31'h0, pin[1]});
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag1", 32'h2, q & 32'h2);
    chk("irq", 32'h1, {31'h0, irq});
  endtask
  initial begin
    cyc(4);
    rst_i <= 1'b0;
    wr(8'h40, 32'hFFFFFFFF);
    for (int i = 0; i < 5; i++) begin
      rd(al[i]);
      chk("reset word", 32'h0, q);
    end
    chk("hresp", 32'h0, {31'h0, hresp});
    $display("test reset done");
    wr(tcc_pkg::ADDR_MODE, 32'h31);
    wr(tcc_pkg::ADDR_ENABLE, 32'h1);
    wr(tcc_pkg::ADDR_IRQCFG, 32'h3);
    wr(tcc_pkg::ADDR_CTRL, 32'h1);
    rd(tcc_pkg::ADDR_COUNT);
    c0 = q;
    lvl <= 2'h1;
    cyc(30);
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag0", 32'h1, q);
    chk("irq", 32'h1, {31'h0, irq});
    lvl <= 2'h0;
    cyc(30);
    lvl <= 2'h1;
    cyc(30);
    rd(tcc_pkg::ADDR_CCR0);
    chk("ccr0", 32'h1, {31'h0, q > c0 + 60 && q < c0 + 120});
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag0 read", 32'h0, q);
    rd(tcc_pkg::ADDR_MISS);
    chk("miss", 32'h1, q);
    wr(tcc_pkg::ADDR_MISS, 32'h1);
    rd(tcc_pkg::ADDR_MISS);
    chk("miss clr", 32'h0, q);
    rd(tcc_pkg::ADDR_CCR0);
    c0 = q;
    wr(tcc_pkg::ADDR_CCR0, 32'h1234);
    rd(tcc_pkg::ADDR_CCR0);
    chk("ccr0 ro", c0, q);
    wr(tcc_pkg::ADDR_ENABLE, 32'h0);
    lvl <= 2'h0;
    cyc(30);
    lvl <= 2'h1;
    cyc(30);
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag0 off", 32'h0, q);
    $display("test capture done");
    pol = 1'($random(seed));
    wr(tcc_pkg::ADDR_ENABLE, {26'h0, pol, 1'b1, 2'h0, pol, 1'b1});
    for (int i = 0; i < 7; i++) begin
      v = 5 + ($random(seed) & 31);
      cmp_run(ml[i], 1'b0, 16'(v));
    end
    cmp_run(tcc_pkg::OCM_CLEAR, 1'b1, 16'h0F00);
    rd(tcc_pkg::ADDR_CCR1);
    chk("ccr1 buffer", 32'h0F00, q);
    wr(tcc_pkg::ADDR_FLAG, 32'h2);
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag1 clr", 32'h0, q & 32'h2);
    wr(tcc_pkg::ADDR_EVGEN, 32'h4);
    cyc(2);
    rd(tcc_pkg::ADDR_FLAG);
    chk("flag1 gen", 32'h2, q & 32'h2);
    wr(tcc_pkg::ADDR_IRQCFG, 32'h0);
    cyc(2);
    chk("irq off", 32'h0, {31'h0, irq});
    $display("test compare done");
    wr(tcc_pkg::ADDR_CTRL, 32'h0);
    wr(tcc_pkg::ADDR_SLAVE, 32'h5000);
    wr(tcc_pkg::ADDR_EVGEN, 32'h1);
    wr(tcc_pkg::ADDR_CTRL, 32'h1);
    h = 2 * (2 + ($random(seed) & 3));
    repeat (h) begin
      external_trigger_input <= 1'b1;
      cyc(6);
      external_trigger_input <= 1'b0;
      cyc(6);
    end
    cyc(10);
    rd(tcc_pkg::ADDR_COUNT);
    chk("ext count", 32'(h / 2), q);
    $display("test ext clock done");
    wr(tcc_pkg::ADDR_SLAVE, 32'h54);
    wr(tcc_pkg::ADDR_MODE, 32'h3231);
    wr(tcc_pkg::ADDR_ENABLE, 32'h31);
    lvl <= 2'h0;
    cyc(20);
    h = 20 + ($random(seed) & 15);
    l = 20 + ($random(seed) & 15);
    repeat (3) begin
      lvl <= 2'h1;
      cyc(h);
      lvl <= 2'h0;
      cyc(l);
    end
    rd(tcc_pkg::ADDR_CCR0);
    chk("period", 32'h1, near(q, h + l));
    rd(tcc_pkg::ADDR_CCR1);
    chk("duty", 32'h1, near(q, h));
    $display("test pwm input done");
    complete_run();
  end
  // Watchdog well beyond the expected run length
  initial begin
    #400000;
    failures++;
    complete_run();
  end
endmodule
